// ===== adcc_defines.vh
// Register offsets, field positions, reset values and result width for the converter control
// Behaviour
// - Setting go/done starts conversion
// - Go/done stays set until conversion ends
// - Completion can raise interrupt when enabled
// - One result bit per bit-conversion period
// - Unimplemented bits read zero, ignore writes
// - Completion loads result, clears go, flags
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH
`define ADCC_OFS_PORT_A 8'h05
`define ADCC_OFS_INT_CTRL 8'h0B
`define ADCC_OFS_FLAGS_ONE 8'h0C
`define ADCC_OFS_RESULT 8'h1E
`define ADCC_OFS_CTRL_MAIN 8'h1F
`define ADCC_OFS_PORT_A_DIR 8'h85
`define ADCC_OFS_ENABLES_ONE 8'h8C
`define ADCC_OFS_PIN_CFG 8'h9F
`define ADCC_CTRL_MASK 8'hFD
`define ADCC_CTRL_GO_BIT 2
`define ADCC_CTRL_PWR_BIT 0
`define ADCC_CTRL_CLK_LSB 6
`define ADCC_CTRL_CHS_LSB 3
`define ADCC_PINCFG_MASK 8'h07
`define ADCC_PORT_A_PINS_MASK 8'h3F
`define ADCC_FLAGS_MASK 8'h40
`define ADCC_EN_MASK 8'h40
`define ADCC_INT_CTRL_MASK 8'hC0
`define ADCC_IRQ_BIT 6
`define ADCC_GIE_BIT 7
`define ADCC_PERIPHERAL_IRQ_ENABLE_BIT 6
`define ADCC_RST_CTRL 8'h00
`define ADCC_RST_PIN_CFG 8'h00
`define ADCC_RST_DIR 8'h3F
`define ADCC_RST_FLAGS 8'h00
`define ADCC_RST_ENABLES 8'h00
`define ADCC_RST_INT_CTRL 8'h00
`define ADCC_BITS 8
`endif

// ===== adcc_control.v
// Converter control: register file, clock divider and successive approximation sequencer
`timescale 1ns/10ps
`include "adcc_defines.vh"
module adcc_control #(
  parameter DIV0 = 2,
  parameter DIV1 = 8,
  parameter DIV2 = 32,
  parameter DIV3 = 64
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire [5:0] port_a_pins_i,
  input wire cmp_high_i,
  output reg [7:0] dac_code_o,
  output reg [2:0] channel_o,
  output reg [2:0] pin_config_o,
  output reg [5:0] port_a_direction_o,
  output reg sample_o,
  output reg power_on_o,
  output wire irq_o
);
  reg [7:0] ctrl_q;
  reg [7:0] pin_cfg_q;
  reg [7:0] dir_q;
  reg [7:0] flags_q;
  reg [7:0] enables_q;
  reg [7:0] int_ctrl_q;
  reg [7:0] result_q;
  reg [7:0] sar_q;
  reg [2:0] bit_q;
  reg [6:0] div_q;
  reg busy_q;
  reg [6:0] div_max;
  wire tad_tick;
  wire done;
  wire go_set;

  // Conversion clock select sets the bit period
  always @*
  begin
    case (ctrl_q[`ADCC_CTRL_CLK_LSB +: 2])
      2'd0: div_max = DIV0[6:0] - 7'd1;
      2'd1: div_max = DIV1[6:0] - 7'd1;
      2'd2: div_max = DIV2[6:0] - 7'd1;
      default: div_max = DIV3[6:0] - 7'd1;
    endcase
  end

  assign tad_tick = busy_q && (div_q == div_max);
  assign done = tad_tick && (bit_q == 3'd0);
  // A start needs power on; a write with go set while idle begins converting
  assign go_set = wr_i && (addr_i == `ADCC_OFS_CTRL_MAIN) && wdata_i[`ADCC_CTRL_GO_BIT]
    && wdata_i[`ADCC_CTRL_PWR_BIT] && !busy_q;

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_q <= `ADCC_RST_CTRL;
      pin_cfg_q <= `ADCC_RST_PIN_CFG;
      dir_q <= `ADCC_RST_DIR;
      flags_q <= `ADCC_RST_FLAGS;
      enables_q <= `ADCC_RST_ENABLES;
      int_ctrl_q <= `ADCC_RST_INT_CTRL;
      result_q <= 8'h00;
      sar_q <= 8'h00;
      bit_q <= 3'd0;
      div_q <= 7'd0;
      busy_q <= 1'b0;
    end
    else
    begin
      if (wr_i)
      begin
        if (addr_i == `ADCC_OFS_CTRL_MAIN)
        begin
          // Go bit is owned by the sequencer; clearing it mid-conversion is ignored
          ctrl_q <= (wdata_i & `ADCC_CTRL_MASK & ~(8'h01 << `ADCC_CTRL_GO_BIT))
            | (ctrl_q & (8'h01 << `ADCC_CTRL_GO_BIT)) | (go_set ? 8'h04 : 8'h00);
        end
        else if (addr_i == `ADCC_OFS_PIN_CFG)
          pin_cfg_q <= wdata_i & `ADCC_PINCFG_MASK;
        else if (addr_i == `ADCC_OFS_PORT_A_DIR)
          dir_q <= wdata_i & `ADCC_PORT_A_PINS_MASK;
        else if (addr_i == `ADCC_OFS_ENABLES_ONE)
          enables_q <= wdata_i & `ADCC_EN_MASK;
        else if (addr_i == `ADCC_OFS_INT_CTRL)
          int_ctrl_q <= wdata_i & `ADCC_INT_CTRL_MASK;
      end
      // Flag write then hardware set: set wins
      if (wr_i && addr_i == `ADCC_OFS_FLAGS_ONE)
        flags_q <= (wdata_i & `ADCC_FLAGS_MASK) | (done ? 8'h40 : 8'h00);
      else if (rd_i && addr_i == `ADCC_OFS_FLAGS_ONE)
        flags_q <= done ? 8'h40 : 8'h00;
      else if (done)
        flags_q[`ADCC_IRQ_BIT] <= 1'b1;
      if (go_set)
      begin
        busy_q <= 1'b1;
        div_q <= 7'd0;
        bit_q <= 3'd7;
        sar_q <= 8'h80;
      end
      else if (busy_q)
      begin
        if (!ctrl_q[`ADCC_CTRL_PWR_BIT])
        begin
          // Power off aborts; old result kept
          busy_q <= 1'b0;
          ctrl_q[`ADCC_CTRL_GO_BIT] <= 1'b0;
        end
        else if (tad_tick)
        begin
          div_q <= 7'd0;
          if (!cmp_high_i)
            sar_q[bit_q] <= 1'b0;
          if (bit_q != 3'd0)
          begin
            sar_q[bit_q - 3'd1] <= 1'b1;
            bit_q <= bit_q - 3'd1;
          end
          else
          begin
            busy_q <= 1'b0;
            ctrl_q[`ADCC_CTRL_GO_BIT] <= 1'b0;
            result_q <= {sar_q[7:1], cmp_high_i};
          end
        end
        else
          div_q <= div_q + 7'd1;
      end
    end
  end

  // result_q only changes on done above
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      if (addr_i == `ADCC_OFS_CTRL_MAIN)
        rdata_o <= ctrl_q;
      else if (addr_i == `ADCC_OFS_PIN_CFG)
        rdata_o <= pin_cfg_q;
      else if (addr_i == `ADCC_OFS_RESULT)
        rdata_o <= result_q;
      else if (addr_i == `ADCC_OFS_FLAGS_ONE)
        rdata_o <= flags_q;
      else if (addr_i == `ADCC_OFS_ENABLES_ONE)
        rdata_o <= enables_q;
      else if (addr_i == `ADCC_OFS_INT_CTRL)
        rdata_o <= int_ctrl_q;
      else if (addr_i == `ADCC_OFS_PORT_A_DIR)
        rdata_o <= dir_q;
      else if (addr_i == `ADCC_OFS_PORT_A)
        rdata_o <= {2'b00, port_a_pins_i};
      else
        rdata_o <= 8'h00;
    end
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dac_code_o <= 8'h00;
      channel_o <= 3'd0;
      pin_config_o <= 3'd0;
      port_a_direction_o <= 6'h3F;
      sample_o <= 1'b0;
      power_on_o <= 1'b0;
    end
    else
    begin
      dac_code_o <= sar_q;
      channel_o <= ctrl_q[`ADCC_CTRL_CHS_LSB +: 3];
      pin_config_o <= pin_cfg_q[2:0];
      port_a_direction_o <= dir_q[5:0];
      // Holder tracks the input whenever powered and idle
      sample_o <= ctrl_q[`ADCC_CTRL_PWR_BIT] && !busy_q;
      power_on_o <= ctrl_q[`ADCC_CTRL_PWR_BIT];
    end
  end

  assign irq_o = flags_q[`ADCC_IRQ_BIT] && enables_q[`ADCC_IRQ_BIT]
    && int_ctrl_q[`ADCC_GIE_BIT] && int_ctrl_q[`ADCC_PERIPHERAL_IRQ_ENABLE_BIT];
endmodule

// ===== adcc_analog_model.sv
// Analog side: selected channel level against the trial code
`timescale 1ns/10ps
module adcc_analog_model (
  input wire [7:0] dac_code_i,
  input wire [2:0] channel_i,
  input wire [63:0] levels_i,
  output wire cmp_high_o
);
  assign cmp_high_o = levels_i[channel_i*8 +: 8] >= dac_code_i;
endmodule

// ===== adcc_chk_assertions.sv
// Port checks for the converter control
`timescale 1ns/10ps
module adcc_chk (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire [5:0] port_a_pins_i,
  input wire [7:0] dac_code_o,
  input wire sample_o,
  input wire power_on_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire wr_ctl = wr_i && addr_i == 8'h1F;
  wire go_w = sample_o && wr_ctl && wdata_i[2] && wdata_i[0];
  a_ctl_bit1: assert property (rd_i && addr_i == 8'h1F |=> !rdata_o[1])
    else $error("ctl bit1 set");
  a_cfg_high: assert property (rd_i && addr_i == 8'h9F |=> rdata_o[7:3] == 5'h00)
    else $error("cfg high set");
  a_dir_high: assert property (rd_i && addr_i == 8'h85 |=> rdata_o[7:6] == 2'h0)
    else $error("dir high set");
  a_unmapped_zero: assert property (rd_i && addr_i == 8'h40 |=> rdata_o == 8'h00)
    else $error("unmapped not zero");
  a_pins_read: assert property (rd_i && addr_i == 8'h05 |=> rdata_o == {2'h0, $past(port_a_pins_i)})
    else $error("pins mismatch");
  a_go_msb: assert property (go_w |-> ##[1:2] dac_code_o == 8'h80)
    else $error("no msb trial");
  a_busy_holds: assert property (go_w |-> ##3 !sample_o [*8])
    else $error("idle too soon");
  a_power_copy: assert property (wr_ctl |-> ##2 power_on_o == $past(wdata_i[0], 2))
    else $error("power copy wrong");
  cover property (go_w);
  cover property (rd_i && addr_i == 8'h1E);
  cover property ($fell(sample_o));
endmodule

// ===== tb_adcc_control.sv
// Self-checking bench for the converter control
`timescale 1ns/10ps
module tb_adcc_control;
  logic clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, cmp, irq;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, dac, d, lv, c;
  logic [5:0] pins = 0, pd;
  logic smp, pwr;
  logic [2:0] pc;
  logic [2:0] ch;
  logic [63:0] levels = 0;
  logic [15:0] ra[6] = '{16'h1F00, 16'h9F00, 16'h853F, 16'h0C00, 16'h8C00, 16'h4000};
  logic [23:0] wt[5] = '{24'h9FFF07, 24'h85FF3F, 24'h0BC0C0, 24'h8CFF40, 24'h0CFF40};
  int n_errors = 0, tests_run = 0, k;
  always #2.5 clk_i = ~clk_i;
  adcc_control uut (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .port_a_pins_i(pins), .cmp_high_i(cmp), .dac_code_o(dac), .channel_o(ch),
    .pin_config_o(pc), .port_a_direction_o(pd), .sample_o(smp), .power_on_o(pwr), .irq_o(irq));
  adcc_analog_model m (.dac_code_i(dac), .channel_i(ch), .levels_i(levels), .cmp_high_o(cmp));
  task automatic chk(input [7:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input [7:0] a, v);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, v, 1'b1};
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 0;
    #1 d = rdata_o;
  endtask
  // Ideal successive approximation, most significant bit first
  function automatic [7:0] sar(input [7:0] v);
    sar = 0;
    for (int b = 7; b >= 0; b--)
      if (v >= (sar | (8'h01 << b))) sar = sar | (8'h01 << b);
  endfunction
  task automatic results;
    $display("errors=%0d tests=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_errors++;
    results;
  end
  initial
  begin
    void'($urandom(84));
    pins = $urandom;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1;
    foreach (ra[i])
    begin
      rd(ra[i][15:8]);
      chk(d, ra[i][7:0]);
    end
    rd(8'h05);
    chk(d, {2'h0, pins});
    foreach (wt[i])
    begin
      wr(wt[i][23:16], wt[i][15:8]);
      rd(wt[i][23:16]);
      chk(d, wt[i][7:0]);
    end
    chk(pc, 8'h07);
    chk(pd, 8'h3F);
    for (int i = 0; i < 8; i++)
    begin
      levels = {$urandom, $urandom};
      levels[7:0] = 8'h00;
      levels[63:56] = 8'hFF;
      c = {i[1:0], i[2:0], 3'h1};
      wr(8'h8C, {1'b0, i[0], 6'h00});
      wr(8'h1F, c);
      repeat (4) @(posedge clk_i);
      chk(pwr, 1);
      chk(ch, i[2:0]);
      chk(smp, 1);
      wr(8'h1F, c | 8'h04);
      rd(8'h1E);
      chk(smp, 0);
      if (i > 0) chk(d, lv);
      lv = levels[i*8 +: 8];
      k = 0;
      d = 8'h04;
      while (d[2] && k < 700)
      begin
        rd(8'h1F);
        k++;
      end
      chk(d, c);
      chk(irq, i[0]);
      rd(8'h0C);
      chk(d & 8'h40, 8'h40);
      chk(irq, 0);
      rd(8'h1E);
      chk(d, sar(lv));
      repeat (128) @(posedge clk_i);
    end
    results;
  end
endmodule
bind adcc_control adcc_chk chk (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .port_a_pins_i, .dac_code_o, .sample_o, .power_on_o);
